// ==== design/oei_pkg.sv ====
/*
 * constants for the overtravel and emergency-stop interlock: register map,
 * field positions, reset values and stop-mode codes.
 * assumes a 32-bit plain register port with an 8-bit byte address.
 */
package oei_pkg;

    // ==========================================================
    // sizes
    localparam int DI_COUNT = 8;
    localparam int SEL_W    = 3;
    localparam int MODE_W   = 3;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_INPUT_MAP  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STOP_MODE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_AUX_CMD    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIVE_STAT  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EVENT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h14;

    // ==========================================================
    // input map fields
    localparam int POS_SEL_LSB   = 0;
    localparam int POS_POL_BIT   = 4;
    localparam int NEG_SEL_LSB   = 8;
    localparam int NEG_POL_BIT   = 12;
    localparam int ESTOP_SEL_LSB = 16;
    localparam int ESTOP_POL_BIT = 20;

    // stop mode fields
    localparam int OT_MODE_LSB    = 0;
    localparam int ESTOP_MODE_LSB = 4;

    // live status fields
    localparam int LS_POS_LIMIT = 0;
    localparam int LS_NEG_LIMIT = 1;
    localparam int LS_ESTOP     = 2;
    localparam int LS_STOPPING  = 3;
    localparam int LS_POS_LOCK  = 4;
    localparam int LS_CAUSE_ES  = 5;

    // event status and mask fields
    localparam int EV_W         = 3;
    localparam int EV_POS_LIMIT = 0;
    localparam int EV_NEG_LIMIT = 1;
    localparam int EV_ESTOP     = 2;

    // ==========================================================
    // stop-mode codes
    localparam logic [MODE_W-1:0] MODE_COAST      = 3'h0;
    localparam logic [MODE_W-1:0] MODE_ZERO_SPEED = 3'h1;
    localparam logic [MODE_W-1:0] MODE_RAMP       = 3'h2;
    localparam logic [MODE_W-1:0] MODE_ESTOP_TRQ  = 3'h3;
    localparam logic [MODE_W-1:0] MODE_DYN_BRAKE  = 3'h4;

    // ==========================================================
    // reset values
    localparam logic [SEL_W-1:0]  RST_POS_SEL    = 3'h0;
    localparam logic [SEL_W-1:0]  RST_NEG_SEL    = 3'h1;
    localparam logic [SEL_W-1:0]  RST_ESTOP_SEL  = 3'h2;
    localparam logic              RST_POL        = 1'h1;
    localparam logic [MODE_W-1:0] RST_OT_MODE    = MODE_ZERO_SPEED;
    localparam logic [MODE_W-1:0] RST_ESTOP_MODE = MODE_ZERO_SPEED;
    localparam logic [EV_W-1:0]   RST_MASK       = 3'h0;

    typedef enum {OEI_RUN, OEI_STOPPING, OEI_LOCKED} oei_state_t;

endpackage

// ==== design/oei_sync.sv ====
/*
 * two-flop synchroniser for the digital input pins.
 * assumes the pins are asynchronous to clock.
 */
`timescale 1ns/10ps
module oei_sync
    import oei_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [DI_COUNT-1:0] pinIn,
    output      logic [DI_COUNT-1:0] pinSync
);

    // ==========================================================
    // stages
    logic [DI_COUNT-1:0] stage1;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1  <= '0;
            pinSync <= '0;
        end else begin
            stage1  <= pinIn;
            pinSync <= stage1;
        end
    end

endmodule

// ==== design/oei_input_map.sv ====
/*
 * picks one synchronised input by index and applies its active level.
 * assumes pinSync is already in the clock domain.
 */
`timescale 1ns/10ps
module oei_input_map
    import oei_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [DI_COUNT-1:0] pinSync,
    input  wire logic [SEL_W-1:0]    select,
    input  wire logic                activeHigh,
    output      logic                asserted
);

    logic next_asserted;

    // ==========================================================
    // selection and polarity
    always_comb begin
        next_asserted = pinSync[select] ~^ activeHigh;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            asserted <= 1'b0;
        end else begin
            asserted <= next_asserted;
        end
    end

endmodule

// ==== design/oei_interlock.sv ====
/*
 * overtravel and emergency-stop interlock: limit inhibit, stop sequencing,
 * position lock, warnings, register port and interrupt.
 * assumes motion requests and motorStopped come from logic on clock;
 * digIn comes from pins and is synchronised here.
 */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module oei_interlock
    import oei_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [DI_COUNT-1:0] digIn,
    input  wire logic                fwdRequest,
    input  wire logic                revRequest,
    input  wire logic                motorStopped,
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic [DATA_W-1:0]   wrData,
    input  wire logic                wrStrobe,
    input  wire logic                rdStrobe,
    output      logic [DATA_W-1:0]   rdData,
    output      logic                fwdDrive,
    output      logic                revDrive,
    output      logic                stopActive,
    output      logic [MODE_W-1:0]   stopMode,
    output      logic                positionLock,
    output      logic                estopWarning,
    output      logic                posLimitWarning,
    output      logic                negLimitWarning,
    output      logic                irq
);

    // ==========================================================
    // input path
    logic [DI_COUNT-1:0] pinSync;
    logic                posLimit;
    logic                negLimit;
    logic                estopInput;
    logic [SEL_W-1:0]    posSel;
    logic                posPol;
    logic [SEL_W-1:0]    negSel;
    logic                negPol;
    logic [SEL_W-1:0]    estopSel;
    logic                estopPol;
    logic [MODE_W-1:0]   otMode;
    logic [MODE_W-1:0]   estopMode;
    logic                auxEstop;
    logic [EV_W-1:0]     eventStat;
    logic [EV_W-1:0]     eventMask;

    oei_sync u_sync (
        .clock   (clock),
        .arst_n  (arst_n),
        .pinIn   (digIn),
        .pinSync (pinSync)
    );
    oei_input_map u_pos_map (
        .clock      (clock),
        .arst_n     (arst_n),
        .pinSync    (pinSync),
        .select     (posSel),
        .activeHigh (posPol),
        .asserted   (posLimit)
    );
    oei_input_map u_neg_map (
        .clock      (clock),
        .arst_n     (arst_n),
        .pinSync    (pinSync),
        .select     (negSel),
        .activeHigh (negPol),
        .asserted   (negLimit)
    );
    oei_input_map u_estop_map (
        .clock      (clock),
        .arst_n     (arst_n),
        .pinSync    (pinSync),
        .select     (estopSel),
        .activeHigh (estopPol),
        .asserted   (estopInput)
    );

    // ==========================================================
    // edge detection
    logic posLimitPrev;
    logic negLimitPrev;
    logic estopPrev;
    logic estopActive;
    logic posRise;
    logic negRise;
    logic estopRise;
    assign estopActive = estopInput | auxEstop;
    assign posRise     = posLimit & ~posLimitPrev;
    assign negRise     = negLimit & ~negLimitPrev;
    assign estopRise   = estopActive & ~estopPrev;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            posLimitPrev <= 1'b0;
            negLimitPrev <= 1'b0;
            estopPrev    <= 1'b0;
        end else begin
            posLimitPrev <= posLimit;
            negLimitPrev <= negLimit;
            estopPrev    <= estopActive;
        end
    end

    // ==========================================================
    // stop sequencer
    oei_state_t        state;
    oei_state_t        next_state;
    logic              causeEstop;
    logic              next_causeEstop;
    logic [MODE_W-1:0] next_stopMode;
    logic              outOfLimit;

    // a command away from the active limit releases the lock
    assign outOfLimit = (~posLimit & ~negLimit)
                      | (posLimit & ~negLimit & revRequest & ~fwdRequest)
                      | (negLimit & ~posLimit & fwdRequest & ~revRequest);
    always_comb begin
        next_state      = state;
        next_causeEstop = causeEstop;
        next_stopMode   = stopMode;
        case (state)
            OEI_RUN: begin
                if (estopActive) begin
                    next_state      = OEI_STOPPING;
                    next_causeEstop = 1'b1;
                    next_stopMode   = estopMode;
                end else if (posRise || negRise) begin
                    next_state      = OEI_STOPPING;
                    next_causeEstop = 1'b0;
                    next_stopMode   = otMode;
                end
            end
            OEI_STOPPING: begin
                if (estopActive && !causeEstop) begin
                    next_causeEstop = 1'b1;
                    next_stopMode   = estopMode;
                end
                if (motorStopped) begin
                    next_state = OEI_LOCKED;
                end
            end
            OEI_LOCKED: begin
                if (estopActive) begin
                    next_causeEstop = 1'b1;
                    next_stopMode   = estopMode;
                end else if (causeEstop || outOfLimit) begin
                    next_state = OEI_RUN;
                end
            end
            default: begin
                next_state = OEI_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state      <= OEI_RUN;
            causeEstop <= 1'b0;
            stopMode   <= RST_OT_MODE;
        end else begin
            state      <= next_state;
            causeEstop <= next_causeEstop;
            stopMode   <= next_stopMode;
        end
    end

    // ==========================================================
    // drive permission and warnings
    logic next_fwdDrive;
    logic next_revDrive;

    always_comb begin
        next_fwdDrive = fwdRequest & ~posLimit & (next_state == OEI_RUN);
        next_revDrive = revRequest & ~negLimit & (next_state == OEI_RUN);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fwdDrive        <= 1'b0;
            revDrive        <= 1'b0;
            stopActive      <= 1'b0;
            positionLock    <= 1'b0;
            estopWarning    <= 1'b0;
            posLimitWarning <= 1'b0;
            negLimitWarning <= 1'b0;
        end else begin
            fwdDrive        <= next_fwdDrive;
            revDrive        <= next_revDrive;
            stopActive      <= (next_state == OEI_STOPPING);
            positionLock    <= (next_state == OEI_LOCKED);
            estopWarning    <= estopActive;
            posLimitWarning <= posLimit;
            negLimitWarning <= negLimit;
        end
    end

    // ==========================================================
    // register port
    logic [DATA_W-1:0] next_rdData;
    logic [DATA_W-1:0] liveStat;
    logic [EV_W-1:0]   next_eventStat;
    logic [EV_W-1:0]   eventSet;
    logic              next_irq;

    always_comb begin
        liveStat               = '0;
        liveStat[LS_POS_LIMIT] = posLimit;
        liveStat[LS_NEG_LIMIT] = negLimit;
        liveStat[LS_ESTOP]     = estopActive;
        liveStat[LS_STOPPING]  = (state == OEI_STOPPING);
        liveStat[LS_POS_LOCK]  = (state == OEI_LOCKED);
        liveStat[LS_CAUSE_ES]  = causeEstop;
        next_rdData = '0;
        if (rdStrobe) begin
            case (address)
                OFS_INPUT_MAP: begin
                    next_rdData[POS_SEL_LSB +: SEL_W]   = posSel;
                    next_rdData[POS_POL_BIT]            = posPol;
                    next_rdData[NEG_SEL_LSB +: SEL_W]   = negSel;
                    next_rdData[NEG_POL_BIT]            = negPol;
                    next_rdData[ESTOP_SEL_LSB +: SEL_W] = estopSel;
                    next_rdData[ESTOP_POL_BIT]          = estopPol;
                end
                OFS_STOP_MODE: begin
                    next_rdData[OT_MODE_LSB +: MODE_W]    = otMode;
                    next_rdData[ESTOP_MODE_LSB +: MODE_W] = estopMode;
                end
                OFS_AUX_CMD:    next_rdData[0]          = auxEstop;
                OFS_LIVE_STAT:  next_rdData             = liveStat;
                OFS_EVENT_STAT: next_rdData[EV_W-1:0]   = eventStat;
                OFS_EVENT_MASK: next_rdData[EV_W-1:0]   = eventMask;
                default:        next_rdData             = '0;
            endcase
        end
        eventSet               = '0;
        eventSet[EV_POS_LIMIT] = posRise;
        eventSet[EV_NEG_LIMIT] = negRise;
        eventSet[EV_ESTOP]     = estopRise;
        next_eventStat = eventStat;
        if (rdStrobe && (address == OFS_EVENT_STAT)) begin
            next_eventStat = '0;
        end
        next_eventStat = next_eventStat | eventSet;
        next_irq       = |(next_eventStat & eventMask);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData    <= '0;
            posSel    <= RST_POS_SEL;
            posPol    <= RST_POL;
            negSel    <= RST_NEG_SEL;
            negPol    <= RST_POL;
            estopSel  <= RST_ESTOP_SEL;
            estopPol  <= RST_POL;
            otMode    <= RST_OT_MODE;
            estopMode <= RST_ESTOP_MODE;
            auxEstop  <= 1'b0;
            eventStat <= '0;
            eventMask <= RST_MASK;
            irq       <= 1'b0;
        end else begin
            rdData    <= next_rdData;
            eventStat <= next_eventStat;
            irq       <= next_irq;
            if (wrStrobe && (address == OFS_INPUT_MAP)) begin
                posSel   <= wrData[POS_SEL_LSB +: SEL_W];
                posPol   <= wrData[POS_POL_BIT];
                negSel   <= wrData[NEG_SEL_LSB +: SEL_W];
                negPol   <= wrData[NEG_POL_BIT];
                estopSel <= wrData[ESTOP_SEL_LSB +: SEL_W];
                estopPol <= wrData[ESTOP_POL_BIT];
            end
            if (wrStrobe && (address == OFS_STOP_MODE)) begin
                otMode    <= wrData[OT_MODE_LSB +: MODE_W];
                estopMode <= wrData[ESTOP_MODE_LSB +: MODE_W];
            end
            if (wrStrobe && (address == OFS_AUX_CMD)) begin
                auxEstop <= wrData[0];
            end
            if (wrStrobe && (address == OFS_EVENT_MASK)) begin
                eventMask <= wrData[EV_W-1:0];
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    fwd_block_a: assert property (posLimit |=> !fwdDrive)
        else $error("forward drive while positive limit active");
    rev_block_a: assert property (negLimit |=> !revDrive)
        else $error("reverse drive while negative limit active");
    both_block_a: assert property (posLimit && negLimit |=> !fwdDrive && !revDrive)
        else $error("drive while both limits active");
    limit_stop_a: assert property ($rose(posLimit) && state == OEI_RUN && !estopActive
                                   |=> stopActive && stopMode == $past(otMode))
        else $error("limit edge did not start overtravel stop");
    estop_mode_a: assert property (estopActive && state == OEI_RUN
                                   |=> stopActive && stopMode == $past(estopMode))
        else $error("estop did not start stop with its mode");
    estop_warn_a: assert property (estopActive |=> estopWarning ##0 !fwdDrive && !revDrive)
        else $error("estop warning missing or drive left on");
    lock_hold_a: assert property (state == OEI_STOPPING && motorStopped && !estopActive
                                  |=> positionLock [*1] ##0 !stopActive)
        else $error("no position lock after motor stopped");
    back_out_a: assert property (state == OEI_LOCKED && !causeEstop && !estopActive
                                 && posLimit && !negLimit && revRequest && !fwdRequest
                                 |=> !positionLock ##1 revDrive || !revRequest || negLimit
                                     || estopActive)
        else $error("reverse move refused after overtravel stop");
    idle_run_a: assert property (state == OEI_RUN && !estopActive && !posRise && !negRise
                                 |=> !stopActive && !positionLock)
        else $error("run state changed without cause");
    limit_warn_a: assert property (negLimit |=> negLimitWarning ##1 $past(negLimit) == negLimitWarning)
        else $error("negative limit warning does not follow input");

endmodule

// ==== dv/oei_motion_partner.sv ====
/*
 * far-side model: limit switches, emergency-stop switch and a motor that
 * reaches zero speed some cycles after drive is removed.
 * assumes the bench drives the switch levels and the stop delay.
 */
`timescale 1ns/10ps
module oei_motion_partner
    import oei_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                posHit,
    input  wire logic                negHit,
    input  wire logic                estopHit,
    input  wire logic [3:0]          stopDelay,
    input  wire logic                fwdDrive,
    input  wire logic                revDrive,
    output      logic [DI_COUNT-1:0] digIn,
    output      logic                motorStopped
);
    // ==========================================================
    // motor speed model
    logic [3:0] idleCount;
    logic [3:0] spare;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idleCount <= 4'h0;
            spare     <= 4'h0;
        end else begin
            spare <= spare + 4'h1;
            if (fwdDrive || revDrive) begin
                idleCount <= 4'h0;
            end else if (idleCount != 4'hF) begin
                idleCount <= idleCount + 4'h1;
            end
        end
    end

    // shaft comes to rest a while after drive goes away
    assign motorStopped = (idleCount >= stopDelay);

    // ==========================================================
    // pins: pos, neg, estop active high on 0..2, neg active low on 3,
    // unused pins 4..7 carry a free-running count
    assign digIn = {spare, ~negHit, estopHit, negHit, posHit};
endmodule

// ==== dv/tb.sv ====
/*
 * self-checking bench for the interlock: register port tasks and motion,
 * limit and emergency-stop sequences with expected values.
 * assumes the partner model drives pins and the motor-stopped flag.
 */
`timescale 1ns/10ps
`define CHECK(got, exp) begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module tb;
    import oei_pkg::*;
    // ==========================================================
    // signals
    logic                clock = 1'b0;
    logic                arst_n = 1'b0;
    logic [DI_COUNT-1:0] digIn;
    logic                fwdRequest = 1'b0;
    logic                revRequest = 1'b0;
    logic                motorStopped;
    logic [ADDR_W-1:0]   address = 8'h00;
    logic [DATA_W-1:0]   wrData = 32'h0;
    logic                wrStrobe = 1'b0;
    logic                rdStrobe = 1'b0;
    logic [DATA_W-1:0]   rdData;
    logic                fwdDrive, revDrive, stopActive, positionLock;
    logic [MODE_W-1:0]   stopMode;
    logic                estopWarning, posLimitWarning, negLimitWarning, irq;
    logic                posHit = 1'b0;
    logic                negHit = 1'b0;
    logic                estopHit = 1'b0;
    int                  miscompares = 0;
    int                  checksDone = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    oei_interlock oei_interlock_i (.clock(clock), .arst_n(arst_n), .digIn(digIn),
        .fwdRequest(fwdRequest), .revRequest(revRequest), .motorStopped(motorStopped),
        .address(address), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .fwdDrive(fwdDrive), .revDrive(revDrive),
        .stopActive(stopActive), .stopMode(stopMode), .positionLock(positionLock),
        .estopWarning(estopWarning), .posLimitWarning(posLimitWarning),
        .negLimitWarning(negLimitWarning), .irq(irq));

    oei_motion_partner oei_motion_partner_i (.clock(clock), .arst_n(arst_n),
        .posHit(posHit), .negHit(negHit), .estopHit(estopHit), .stopDelay(4'h6),
        .fwdDrive(fwdDrive), .revDrive(revDrive), .digIn(digIn),
        .motorStopped(motorStopped));

    // ==========================================================
    // tasks
    task automatic finishTest();
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        address  <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask

    task automatic busRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        address  <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1;
        `CHECK(rdData, exp)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // sel 0 waits for stopActive, sel 1 for positionLock
    task automatic waitHigh(input int sel);
        int n;
        n = 0;
        while (((sel == 0) ? stopActive : positionLock) !== 1'b1) begin
            idle(1);
            n++;
            if (n > 40) begin
                miscompares++;
                finishTest();
            end
        end
    endtask

    // ==========================================================
    // sequence
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        idle(6);
        busRead(OFS_INPUT_MAP, 32'h00121110);
        busRead(OFS_STOP_MODE, 32'h00000011);
        busRead(OFS_AUX_CMD, 32'h0);
        busRead(OFS_EVENT_MASK, 32'h0);
        busWrite(8'h20, 32'hFFFFFFFF);
        busRead(8'h20, 32'h0);
        busWrite(OFS_LIVE_STAT, 32'hFFFFFFFF);
        busRead(OFS_LIVE_STAT, 32'h0);
        busWrite(OFS_EVENT_MASK, 32'h7);
        @(posedge clock) fwdRequest <= 1'b1;
        idle(2);
        `CHECK(fwdDrive, 1'b1)
        idle(4);
        `CHECK(fwdDrive, 1'b1)
        @(posedge clock) posHit <= 1'b1;
        waitHigh(0);
        `CHECK(stopMode, MODE_ZERO_SPEED)
        `CHECK(posLimitWarning, 1'b1)
        `CHECK(negLimitWarning, 1'b0)
        `CHECK(fwdDrive, 1'b0)
        waitHigh(1);
        idle(5);
        `CHECK(positionLock, 1'b1)
        `CHECK(fwdDrive, 1'b0)
        `CHECK(irq, 1'b1)
        busRead(OFS_EVENT_STAT, 32'h1);
        idle(1);
        `CHECK(irq, 1'b0)
        @(posedge clock) begin
            fwdRequest <= 1'b0;
            revRequest <= 1'b1;
        end
        idle(2);
        `CHECK(revDrive, 1'b1)
        `CHECK(positionLock, 1'b0)
        @(posedge clock) posHit <= 1'b0;
        busWrite(OFS_INPUT_MAP, 32'h00120310);
        busRead(OFS_INPUT_MAP, 32'h00120310);
        busWrite(OFS_STOP_MODE, 32'h00000032);
        busRead(OFS_STOP_MODE, 32'h00000032);
        @(posedge clock) negHit <= 1'b1;
        waitHigh(0);
        `CHECK(stopMode, MODE_RAMP)
        `CHECK(negLimitWarning, 1'b1)
        `CHECK(revDrive, 1'b0)
        waitHigh(1);
        @(posedge clock) begin
            posHit     <= 1'b1;
            revRequest <= 1'b0;
            fwdRequest <= 1'b1;
        end
        idle(6);
        `CHECK(fwdDrive, 1'b0)
        @(posedge clock) begin
            revRequest <= 1'b1;
            fwdRequest <= 1'b0;
        end
        idle(3);
        `CHECK(revDrive, 1'b0)
        @(posedge clock) posHit <= 1'b0;
        idle(6);
        `CHECK(revDrive, 1'b0)
        @(posedge clock) begin
            revRequest <= 1'b0;
            fwdRequest <= 1'b1;
        end
        idle(3);
        `CHECK(fwdDrive, 1'b1)
        busRead(OFS_EVENT_STAT, 32'h3);
        @(posedge clock) begin
            negHit     <= 1'b0;
            fwdRequest <= 1'b0;
        end
        idle(6);
        busWrite(OFS_AUX_CMD, 32'h1);
        waitHigh(0);
        `CHECK(stopMode, MODE_ESTOP_TRQ)
        `CHECK(estopWarning, 1'b1)
        waitHigh(1);
        busRead(OFS_LIVE_STAT, 32'h34);
        busWrite(OFS_AUX_CMD, 32'h0);
        idle(3);
        `CHECK(positionLock, 1'b0)
        `CHECK(estopWarning, 1'b0)
        busWrite(OFS_STOP_MODE, 32'h00000042);
        busWrite(OFS_EVENT_MASK, 32'h3);
        busRead(OFS_EVENT_STAT, 32'h4);
        @(posedge clock) fwdRequest <= 1'b1;
        idle(3);
        @(posedge clock) estopHit <= 1'b1;
        waitHigh(0);
        `CHECK(stopMode, MODE_DYN_BRAKE)
        `CHECK(fwdDrive, 1'b0)
        `CHECK(irq, 1'b0)
        waitHigh(1);
        @(posedge clock) estopHit <= 1'b0;
        idle(6);
        `CHECK(fwdDrive, 1'b1)
        busRead(OFS_EVENT_STAT, 32'h4);
        finishTest();
    end
endmodule
